//--- inc/adtc_defs.vh
`ifndef ADTC_DEFS_VH
`define ADTC_DEFS_VH

// Printed register index and its APB byte address (index times four)
`define ADTC_IDX_TIMING      8'h27
`define ADTC_ADDR_TIMING     12'h09c
`define ADTC_ADDR_CTRL       12'h0a0
`define ADTC_ADDR_STATUS     12'h0a4
`define ADTC_ADDR_ESTIMATE   12'h0a8

// Timing register fields
`define ADTC_BIT_MIN_FREQ    7
`define ADTC_BIT_RESYNC      6
`define ADTC_BIT_RSVD        5
`define ADTC_DT_MSB          4
`define ADTC_DT_LSB          0
`define ADTC_TIMING_RESET    8'h10

// Control register fields
`define ADTC_BIT_ENABLE      0
`define ADTC_BIT_MODE        1
`define ADTC_CTRL_RESET      2'h0

// Status register fields
`define ADTC_BIT_LOCKED      0
`define ADTC_BIT_PHASE       1

// Clock and drive-time decode
`define ADTC_CLK_MHZ         10
`define ADTC_RES_BASE_US     500
`define ADTC_RES_STEP_US     100
`define ADTC_ROT_BASE_US     1000
`define ADTC_ROT_STEP_US     200
`define ADTC_MINF_HI_HZ      125
`define ADTC_MINF_LO_HZ      45
`define ADTC_US_PER_S        1000000

// Resync limit from drive time: 1.25 = 1 + 1/4
`define ADTC_RESYNC_SHIFT    2

`define ADTC_CW              20

`endif

//--- design/adtc_timer.v
`include "adtc_defs.vh"

module adtc_timer #(
    parameter W = `ADTC_CW
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         run,
    input  wire         restart,
    input  wire [W-1:0] period,
    output wire         tick,
    output wire [W-1:0] elapsed
);

    reg  [W-1:0] cnt_r;
    reg  [W-1:0] cnt_nxt;
    wire         at_end;

    assign at_end  = (cnt_r >= period - {{(W-1){1'b0}}, 1'b1});
    assign tick    = run & ~restart & at_end;
    assign elapsed = cnt_r;

    always @* begin
        cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
        if (!run || restart || at_end) begin
            cnt_nxt = {W{1'b0}};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= {W{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule

//--- design/adtc_top.v
// Functional notes
// - Timing bit 7 picks the lowest resonant frequency, 0 for 125 Hz and 1 for 45 Hz, reset 0.
// - Timing bit 6 picks the resync limit, 0 from the frequency pick, 1 from drive time x 1.25.
// - In resonant mode the five-bit drive-time code (reset 16) seeds a self-adjusting estimate.
// - Without valid back-EMF the drive free-runs at the half-period set by the code.
// - In rotating-mass mode the code sets the back-EMF sampling period.
// - Code n decodes to 0.5 ms + n x 0.1 ms resonant, or 1 ms + n x 0.2 ms rotating-mass.
//
// The implementer's own choice: the APB slave port.
`include "adtc_defs.vh"

module adtc_top #(
    parameter [`ADTC_CW-1:0] RES_BASE_CYC = `ADTC_RES_BASE_US * `ADTC_CLK_MHZ,
    parameter [`ADTC_CW-1:0] RES_STEP_CYC = `ADTC_RES_STEP_US * `ADTC_CLK_MHZ,
    parameter [`ADTC_CW-1:0] ROT_BASE_CYC = `ADTC_ROT_BASE_US * `ADTC_CLK_MHZ,
    parameter [`ADTC_CW-1:0] ROT_STEP_CYC = `ADTC_ROT_STEP_US * `ADTC_CLK_MHZ,
    parameter [`ADTC_CW-1:0] MINF_HI_CYC  =
        (`ADTC_US_PER_S / (2 * `ADTC_MINF_HI_HZ)) * `ADTC_CLK_MHZ,
    parameter [`ADTC_CW-1:0] MINF_LO_CYC  =
        (`ADTC_US_PER_S / (2 * `ADTC_MINF_LO_HZ)) * `ADTC_CLK_MHZ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        back_emf_valid,
    input  wire        back_emf_zero_cross,
    output reg         drive_enable,
    output reg         drive_polarity,
    output reg         back_emf_sample,
    output reg         min_freq_select,
    output reg         resync_method
);

    localparam CW = `ADTC_CW;
    localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    reg  [7:0]    timing_r;
    reg  [1:0]    ctrl_r;
    reg           locked_r;
    reg  [CW-1:0] est_r;
    reg  [CW-1:0] est_nxt;
    reg           locked_nxt;
    reg  [31:0]   rdata_nxt;
    reg           hit;

    wire          apb_acc  = psel & penable;
    wire          apb_wr   = apb_acc & pwrite;
    // Read data is captured in the setup cycle, so it already stands at the
    // access edge where the master takes it; no wait state is needed
    wire          apb_rd   = psel & ~penable & ~pwrite;
    wire          enabled  = ctrl_r[`ADTC_BIT_ENABLE];
    wire          rot_mode = ctrl_r[`ADTC_BIT_MODE];
    wire [4:0]    dt_code  = timing_r[`ADTC_DT_MSB:`ADTC_DT_LSB];
    wire          wr_timing = apb_wr && (paddr == `ADTC_ADDR_TIMING);
    wire          wr_ctrl   = apb_wr && (paddr == `ADTC_ADDR_CTRL);

    // Zero wait states keeps the slave trivially timed
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~hit;

    always @* begin
        hit       = 1'b1;
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `ADTC_ADDR_TIMING:   rdata_nxt[7:0] = timing_r;
            `ADTC_ADDR_CTRL:     rdata_nxt[1:0] = ctrl_r;
            `ADTC_ADDR_STATUS: begin
                rdata_nxt[`ADTC_BIT_LOCKED] = locked_r;
                rdata_nxt[`ADTC_BIT_PHASE]  = drive_polarity;
            end
            `ADTC_ADDR_ESTIMATE: rdata_nxt[CW-1:0] = est_r;
            default:             hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing_r <= `ADTC_TIMING_RESET;
            ctrl_r   <= `ADTC_CTRL_RESET;
            prdata   <= 32'h0000_0000;
        end else begin
            if (wr_timing) begin
                timing_r <= pwdata[7:0];
            end
            if (wr_ctrl) begin
                ctrl_r <= pwdata[1:0];
            end
            if (apb_rd) begin
                prdata <= rdata_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive-time decode and resync limit

    wire [CW-1:0] code_w   = {{(CW-5){1'b0}}, dt_code};
    wire [CW-1:0] res_cyc  = RES_BASE_CYC + code_w * RES_STEP_CYC;
    wire [CW-1:0] rot_cyc  = ROT_BASE_CYC + code_w * ROT_STEP_CYC;
    wire [CW-1:0] minf_cyc = timing_r[`ADTC_BIT_MIN_FREQ] ? MINF_LO_CYC : MINF_HI_CYC;
    wire [CW-1:0] dt_125   = est_r + (est_r >> `ADTC_RESYNC_SHIFT);
    wire [CW-1:0] resync_lim = timing_r[`ADTC_BIT_RESYNC] ? dt_125 : minf_cyc;

    ////////////////////////////////////////////////////////////////////////
    // Half-period timer: drive flips in resonant mode, sample strobe in
    // rotating-mass mode

    wire [CW-1:0] period = rot_mode ? rot_cyc : est_r;
    wire          tick;
    wire          zc_ok = back_emf_zero_cross & back_emf_valid & enabled & ~rot_mode;
    reg  [CW-1:0] since_zc_r;
    wire          resync_due = (since_zc_r >= resync_lim);

    adtc_timer #(
        .W       (CW)
    ) u_half (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (enabled),
        .restart (wr_timing | wr_ctrl),
        .period  (period),
        .tick    (tick),
        .elapsed ()
    );

    ////////////////////////////////////////////////////////////////////////
    // Resonance tracking

    // Averaging halves the step so one noisy crossing cannot upset the loop
    always @* begin
        est_nxt    = est_r;
        locked_nxt = locked_r;
        if (!locked_r) begin
            est_nxt = res_cyc;
        end
        if (!back_emf_valid || resync_due || !enabled || rot_mode) begin
            locked_nxt = 1'b0;
        end
        if (zc_ok) begin
            locked_nxt = 1'b1;
            if (locked_r) begin
                est_nxt = (est_r >> 1) + (since_zc_r >> 1);
            end
        end
        if (wr_timing) begin
            est_nxt    = {{(CW-5){1'b0}}, pwdata[`ADTC_DT_MSB:`ADTC_DT_LSB]} * RES_STEP_CYC
                         + RES_BASE_CYC;
            locked_nxt = 1'b0;
        end
        if (est_nxt == {CW{1'b0}}) begin
            est_nxt = ONE;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            est_r      <= {CW{1'b0}};
            locked_r   <= 1'b0;
            since_zc_r <= {CW{1'b0}};
        end else begin
            est_r    <= est_nxt;
            locked_r <= locked_nxt;
            if (zc_ok || !enabled) begin
                since_zc_r <= {CW{1'b0}};
            end else if (since_zc_r != {CW{1'b1}}) begin
                since_zc_r <= since_zc_r + ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs toward the output stage

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_enable    <= 1'b0;
            drive_polarity  <= 1'b0;
            back_emf_sample <= 1'b0;
            min_freq_select <= 1'b0;
            resync_method   <= 1'b0;
        end else begin
            drive_enable    <= enabled;
            min_freq_select <= timing_r[`ADTC_BIT_MIN_FREQ];
            resync_method   <= timing_r[`ADTC_BIT_RESYNC];
            back_emf_sample <= tick & rot_mode;
            if (!enabled || rot_mode) begin
                drive_polarity <= 1'b0;
            end else if (tick) begin
                drive_polarity <= ~drive_polarity;
            end
        end
    end

endmodule

//--- verification/adtc_checker.sv
`include "adtc_defs.vh"
module adtc_checker #(parameter int ROT_BASE_CYC = 100) (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic        drive_enable,
    input logic        drive_polarity,
    input logic        back_emf_sample,
    input logic        min_freq_select,
    input logic        resync_method
);
    timeunit 1ns / 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire         tw = psel && penable && pwrite && paddr == `ADTC_ADDR_TIMING;
    logic [15:0] gap_r;
    // Saturates so a long idle spell cannot wrap into a false short gap
    always @(posedge pclk or negedge presetn)
        if (!presetn) gap_r <= 16'h0;
        else gap_r <= back_emf_sample ? 16'h1 : gap_r + {15'h0, ~&gap_r};
    ////////////////////////////////////////
    AST_RST_OUT: assert property ($rose(presetn) |-> !min_freq_select && !resync_method)
        else $error("select outputs set at reset");
    AST_MINF_WR: assert property (tw |-> ##2 min_freq_select == $past(pwdata[7], 2))
        else $error("min_freq_select not from write");
    AST_RSYNC_WR: assert property (tw |-> ##2 resync_method == $past(pwdata[6], 2))
        else $error("resync_method not from write");
    AST_MINF_HOLD: assert property ($changed(min_freq_select) |-> $past(tw) || $past(tw, 2))
        else $error("min_freq_select moved unwritten");
    AST_SAMPLE_PULSE: assert property (back_emf_sample |=> !back_emf_sample)
        else $error("sample pulse too long");
    AST_SAMPLE_GAP: assert property (back_emf_sample |-> gap_r >= ROT_BASE_CYC)
        else $error("sample period too short");
    AST_POL_OFF: assert property (!drive_enable [*3] |-> !drive_polarity)
        else $error("polarity set while disabled");
    cover property (back_emf_sample);
    cover property ($rose(drive_polarity));
    cover property ($rose(min_freq_select));
endmodule

//--- verification/adtc_actuator_model.sv
module adtc_actuator_model #(parameter int HALF = 50) (
    input  logic pclk,
    input  logic present,
    input  logic swing,
    output logic back_emf_valid,
    output logic back_emf_zero_cross
);
    timeunit 1ns / 1ns;
    int cnt_r = 0;
    assign back_emf_valid = present;
    always @(posedge pclk) begin
        cnt_r <= (!swing || cnt_r == HALF - 1) ? 0 : cnt_r + 1;
        back_emf_zero_cross <= present && swing && cnt_r == HALF - 1;
    end
endmodule

//--- verification/adtc_top_bench.sv
`include "adtc_defs.vh"
module adtc_top_bench;
    timeunit 1ns / 1ns;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        present = 1'h0, swing = 1'h0, arm = 1'h0, pol_q = 1'h0;
    logic        pready, pslverr, drive_enable, drive_polarity, back_emf_sample;
    logic        min_freq_select, resync_method, back_emf_valid, back_emf_zero_cross;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, v, rnd = 32'hf59221eb;
    logic [63:0] exp_q[$];
    int          num_errors = 0, comparisons = 0, cycles = 0, gap = 0, evn = 0;
    wire         ev = drive_polarity !== pol_q || back_emf_sample === 1'h1;
    initial forever #50 pclk = ~pclk;
    adtc_top #(.RES_BASE_CYC(20'h32), .RES_STEP_CYC(20'ha), .ROT_BASE_CYC(20'h64),
        .ROT_STEP_CYC(20'h14), .MINF_HI_CYC(20'h190)) uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .back_emf_valid, .back_emf_zero_cross, .drive_enable, .drive_polarity,
        .back_emf_sample, .min_freq_select, .resync_method);
    adtc_actuator_model far_i (.pclk, .present, .swing, .back_emf_valid,
        .back_emf_zero_cross);
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'h0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // Read data is judged at the access edge, where pready is sampled high
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back({m, e});
        apb(a, 1'h0, 32'h0);
    endtask
    task automatic gap_of(input logic [31:0] want);
        @(evn);
        exp_q.push_back({32'hffffffff, want});
        arm <= 1'h1;
        @(evn);
        arm <= 1'h0;
    endtask
    task automatic results;
        if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    always @(posedge pclk) begin
        logic [63:0] e;
        if (psel && penable && pready === 1'h1) begin
            chk({31'h0, pslverr}, {31'h0, !(paddr inside {`ADTC_ADDR_TIMING, `ADTC_ADDR_CTRL,
                `ADTC_ADDR_STATUS, `ADTC_ADDR_ESTIMATE})});
            if (!pwrite && exp_q.size() > 0) begin
                e = exp_q.pop_front();
                chk(prdata & e[63:32], e[31:0]);
            end
        end
        if (ev && arm && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(gap, e[31:0]);
        end
        pol_q <= drive_polarity;
        gap <= ev ? 1 : gap + 1;
        if (ev) evn <= evn + 1;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rd(`ADTC_ADDR_TIMING, 32'hffffffff, 32'h10);
        rd(12'h0fc, 32'hffffffff, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            apb(`ADTC_ADDR_TIMING, 1'h1, rnd);
            rd(`ADTC_ADDR_TIMING, 32'hffffffff, {24'h0, rnd[7:0]});
        end
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 2; k++) begin
                rnd = lfsr(rnd);
                v = {27'h0, rnd[4:0]};
                apb(`ADTC_ADDR_TIMING, 1'h1, v);
                apb(`ADTC_ADDR_CTRL, 1'h1, {30'h0, m[0], 1'h1});
                if (m == 0) rd(`ADTC_ADDR_ESTIMATE, 32'hfffff, 32'h32 + 32'ha * v);
                gap_of(m ? 32'h64 + 32'h14 * v : 32'h32 + 32'ha * v);
                apb(`ADTC_ADDR_CTRL, 1'h1, 32'h0);
                repeat (4) @(posedge pclk);
            end
        end
        present <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            // Code 0 sits at half the 100-cycle swing period
            apb(`ADTC_ADDR_TIMING, 1'h1, i == 0 ? 32'h80 : i == 1 ? 32'h0 : 32'hc0);
            apb(`ADTC_ADDR_CTRL, 1'h1, 32'h1);
            swing <= 1'h1;
            repeat (300) @(posedge pclk);
            rd(`ADTC_ADDR_STATUS, 32'h1, 32'h1);
            swing <= 1'h0;
            // The 45 Hz limit outlasts the 600 idle cycles; the reset 125 Hz limit (400 cycles) does not
            repeat (i == 2 ? 200 : 600) @(posedge pclk);
            rd(`ADTC_ADDR_STATUS, 32'h1, {31'h0, i == 0});
            apb(`ADTC_ADDR_CTRL, 1'h1, 32'h0);
        end
        results();
    end
endmodule
bind adtc_top adtc_checker #(.ROT_BASE_CYC(ROT_BASE_CYC)) chk_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .drive_enable, .drive_polarity, .back_emf_sample,
    .min_freq_select, .resync_method);
